// ===== core/ipo_store.sv
// address override store with log retention and link status report
`timescale 1ns/10ps
// Operation
// - write-request rising edge copies the six data registers into storage
// - storage holds own address, subnet mask and default router only
// - mask and router both zero together is accepted as no setting
// - only one of mask or router zero flags error, storage kept
// - requests accepted in run and stop mode alike
// - stored values applied at next power-up, enabled flag then set
// - empty storage keeps flag low and uses parameter settings
// - clear-request rising edge erases the storage area
// - full memory clear also erases the storage area
// - after erase, parameter address active at next power-up
// - parameter transfers ignored while override is enabled
// - storage is internal, unaffected by cassette swap
// - error and access logs recorded only when logging configured
// - batteryless mode clears logs and time status at every power-up
// - link report shows duplex, link state and speed
module ipo_store #(
  parameter int NV_PROG_CYCLES = ipo_pkg::NV_PROG_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [15:0] override_data_regs [ipo_pkg::DATA_REGS],
  input  wire logic        override_write_request,
  input  wire logic        override_clear_request,
  input  wire logic        memory_clear_request,
  input  wire logic        power_up,
  input  wire logic [31:0] param_own_addr,
  input  wire logic [31:0] param_mask,
  input  wire logic [31:0] param_router,
  input  wire logic        cassette_present,
  input  wire logic        log_enable,
  input  wire logic        log_latched,
  input  wire logic        batteryless_mode,
  input  wire logic        error_event,
  input  wire logic [15:0] error_code,
  input  wire logic        access_event,
  input  wire logic        time_set_event,
  input  wire logic [31:0] time_set_value,
  input  wire logic        phy_full_duplex,
  input  wire logic        phy_link_up,
  input  wire logic        phy_fast,
  output logic             override_enabled_flag,
  output logic [31:0]      active_own_addr,
  output logic [31:0]      active_mask,
  output logic [31:0]      active_router,
  output logic             store_busy,
  output logic             store_valid,
  output logic             write_done,
  output logic             clear_done,
  output logic             write_error,
  output logic [7:0]       error_log_count,
  output logic [15:0]      error_log_last,
  output logic [7:0]       access_log_count,
  output logic             time_set_valid,
  output logic [31:0]      time_set_last,
  output logic [2:0]       link_status
);

  //////////////////////////////////////////////////////////////////////////
  // helper functions

  // join two data registers into one address, upper register first
  function automatic logic [31:0] join_addr(
    input logic [15:0] hi,
    input logic [15:0] lo
  );
    join_addr = {hi[ipo_pkg::OCT_HI_MSB:ipo_pkg::OCT_HI_LSB],
                 hi[ipo_pkg::OCT_LO_MSB:ipo_pkg::OCT_LO_LSB],
                 lo[ipo_pkg::OCT_HI_MSB:ipo_pkg::OCT_HI_LSB],
                 lo[ipo_pkg::OCT_LO_MSB:ipo_pkg::OCT_LO_LSB]};
  endfunction : join_addr

  // all-zero address means no setting
  function automatic logic is_unset(input logic [31:0] a);
    is_unset = (a == ipo_pkg::ADDR_ZERO);
  endfunction : is_unset

  //////////////////////////////////////////////////////////////////////////
  // request edges

  logic [ipo_pkg::REQ_LINES-1:0] req_level;
  logic [ipo_pkg::REQ_LINES-1:0] req_rise;

  assign req_level[ipo_pkg::REQ_WRITE]  = override_write_request;
  assign req_level[ipo_pkg::REQ_CLEAR]  = override_clear_request;
  assign req_level[ipo_pkg::REQ_MEMCLR] = memory_clear_request;

  // each relay acts once per off-to-on change
  ipo_edge #(
    .WIDTH (ipo_pkg::REQ_LINES)
  ) u_edge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .level   (req_level),
    .rise    (req_rise)
  );

  logic write_req;
  logic erase_req;

  // no run/stop gating on either request
  assign write_req = req_rise[ipo_pkg::REQ_WRITE];
  assign erase_req = req_rise[ipo_pkg::REQ_CLEAR]
                   | req_rise[ipo_pkg::REQ_MEMCLR];

  //////////////////////////////////////////////////////////////////////////
  // candidate check

  logic [31:0] cand_own;
  logic [31:0] cand_mask;
  logic [31:0] cand_router;
  logic        cand_ok;

  // three items only, taken from register pairs
  assign cand_own    = join_addr(override_data_regs[ipo_pkg::IDX_OWN],
                                 override_data_regs[ipo_pkg::IDX_OWN+1]);
  assign cand_mask   = join_addr(override_data_regs[ipo_pkg::IDX_MASK],
                                 override_data_regs[ipo_pkg::IDX_MASK+1]);
  assign cand_router = join_addr(override_data_regs[ipo_pkg::IDX_ROUTER],
                                 override_data_regs[ipo_pkg::IDX_ROUTER+1]);

  // mask and router unset only as a pair; own address in range
  assign cand_ok = (is_unset(cand_mask) == is_unset(cand_router))
                 && (cand_own >= ipo_pkg::OWN_ADDR_MIN)
                 && (cand_own <= ipo_pkg::OWN_ADDR_MAX);

  //////////////////////////////////////////////////////////////////////////
  // storage sequencer

  ipo_pkg::ipo_state_t                 state;
  ipo_pkg::ipo_op_t                    op;
  logic [ipo_pkg::PROG_CNT_W-1:0]      prog_cnt;
  logic [31:0]                         hold_own;
  logic [31:0]                         hold_mask;
  logic [31:0]                         hold_router;

  // accept a request when idle, program for the storage time, then finish
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state       <= ipo_pkg::IPO_IDLE;
      op          <= ipo_pkg::IPO_OP_NONE;
      prog_cnt    <= '0;
      hold_own    <= ipo_pkg::ADDR_ZERO;
      hold_mask   <= ipo_pkg::ADDR_ZERO;
      hold_router <= ipo_pkg::ADDR_ZERO;
    end else if (ce) begin
      unique case (state)
        ipo_pkg::IPO_IDLE: begin
          if (erase_req) begin
            op       <= ipo_pkg::IPO_OP_ERASE;
            prog_cnt <= ipo_pkg::PROG_CNT_W'(NV_PROG_CYCLES - 1);
            state    <= ipo_pkg::IPO_PROG;
          end else if (write_req && cand_ok) begin
            op          <= ipo_pkg::IPO_OP_WRITE;
            hold_own    <= cand_own;
            hold_mask   <= cand_mask;
            hold_router <= cand_router;
            prog_cnt    <= ipo_pkg::PROG_CNT_W'(NV_PROG_CYCLES - 1);
            state       <= ipo_pkg::IPO_PROG;
          end
        end
        ipo_pkg::IPO_PROG: begin
          if (prog_cnt == '0) begin
            state <= ipo_pkg::IPO_DONE;
          end else begin
            prog_cnt <= prog_cnt - 1'b1;
          end
        end
        ipo_pkg::IPO_DONE: begin
          op    <= ipo_pkg::IPO_OP_NONE;
          state <= ipo_pkg::IPO_IDLE;
        end
        default: begin
          op    <= ipo_pkg::IPO_OP_NONE;
          state <= ipo_pkg::IPO_IDLE;
        end
      endcase
    end
  end

  assign store_busy = (state != ipo_pkg::IPO_IDLE);

  //////////////////////////////////////////////////////////////////////////
  // non-volatile storage area

  logic [31:0] nv_item [3];

  // internal storage only; cassette presence never touches it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      store_valid <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        nv_item[i] <= ipo_pkg::ADDR_ZERO;
      end
    end else if (ce && state == ipo_pkg::IPO_DONE) begin
      if (op == ipo_pkg::IPO_OP_WRITE) begin
        store_valid <= 1'b1;
        nv_item[0]  <= hold_own;
        nv_item[1]  <= hold_mask;
        nv_item[2]  <= hold_router;
      end else if (op == ipo_pkg::IPO_OP_ERASE) begin
        store_valid <= 1'b0;
        for (int i = 0; i < 3; i++) begin
          nv_item[i] <= ipo_pkg::ADDR_ZERO;
        end
      end
    end
  end

  // completion and refusal pulses
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      write_done  <= 1'b0;
      clear_done  <= 1'b0;
      write_error <= 1'b0;
    end else if (ce) begin
      write_done  <= (state == ipo_pkg::IPO_DONE)
                   && (op == ipo_pkg::IPO_OP_WRITE);
      clear_done  <= (state == ipo_pkg::IPO_DONE)
                   && (op == ipo_pkg::IPO_OP_ERASE);
      write_error <= write_req && !cand_ok && !erase_req
                   && (state == ipo_pkg::IPO_IDLE);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // address applied at power-up

  // stored set wins when present, else parameter settings
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      override_enabled_flag <= 1'b0;
      active_own_addr       <= ipo_pkg::ADDR_ZERO;
      active_mask           <= ipo_pkg::ADDR_ZERO;
      active_router         <= ipo_pkg::ADDR_ZERO;
    end else if (ce && power_up) begin
      if (store_valid) begin
        override_enabled_flag <= 1'b1;
        active_own_addr       <= nv_item[0];
        active_mask           <= nv_item[1];
        active_router         <= nv_item[2];
      end else begin
        override_enabled_flag <= 1'b0;
        active_own_addr       <= param_own_addr;
        active_mask           <= param_mask;
        active_router         <= param_router;
      end
    end
    // between power-ups parameter transfers leave the address alone
  end

  //////////////////////////////////////////////////////////////////////////
  // diagnostic logs

  logic log_wipe;

  // wipe at power-up when not latched, or always when batteryless
  assign log_wipe = power_up && (batteryless_mode || !log_latched);

  // error history counter and last code
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      error_log_count <= '0;
      error_log_last  <= '0;
    end else if (ce) begin
      if (log_wipe) begin
        error_log_count <= '0;
        error_log_last  <= '0;
      end else if (error_event && log_enable) begin
        error_log_last <= error_code;
        if (error_log_count != ipo_pkg::LOG_CNT_MAX) begin
          error_log_count <= error_log_count + ipo_pkg::LOG_CNT_ONE;
        end
      end
    end
  end

  // access history counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      access_log_count <= '0;
    end else if (ce) begin
      if (log_wipe) begin
        access_log_count <= '0;
      end else if (access_event && log_enable
                   && access_log_count != ipo_pkg::LOG_CNT_MAX) begin
        access_log_count <= access_log_count + ipo_pkg::LOG_CNT_ONE;
      end
    end
  end

  // time setting status
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      time_set_valid <= 1'b0;
      time_set_last  <= '0;
    end else if (ce) begin
      if (log_wipe) begin
        time_set_valid <= 1'b0;
        time_set_last  <= '0;
      end else if (time_set_event) begin
        time_set_valid <= 1'b1;
        time_set_last  <= time_set_value;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link status report

  // registered duplex, link and speed bits
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      link_status <= '0;
    end else if (ce) begin
      link_status[ipo_pkg::LNK_DUPLEX] <= phy_full_duplex;
      link_status[ipo_pkg::LNK_UP]     <= phy_link_up;
      link_status[ipo_pkg::LNK_FAST]   <= phy_fast;
    end
  end

  // cassette presence is deliberately unused by the storage path
  logic unused_cassette;
  assign unused_cassette = cassette_present;

endmodule : ipo_store

// ===== inc/ipo_pkg.sv
// shared constants and types of the address override store
package ipo_pkg;

  // data register layout: six 16-bit registers, two octets each
  localparam int          DATA_REGS     = 6;
  localparam int          REG_W         = 16;
  localparam int          ADDR_W        = 32;
  localparam int          OCT_HI_MSB    = 15;
  localparam int          OCT_HI_LSB    = 8;
  localparam int          OCT_LO_MSB    = 7;
  localparam int          OCT_LO_LSB    = 0;
  // register index of each item's upper half
  localparam int          IDX_OWN       = 0;
  localparam int          IDX_MASK      = 2;
  localparam int          IDX_ROUTER    = 4;

  // number of request lines watched for rising edges
  localparam int          REQ_LINES     = 3;
  localparam int          REQ_WRITE     = 0;
  localparam int          REQ_CLEAR     = 1;
  localparam int          REQ_MEMCLR    = 2;

  // permitted range of the adapter's own address
  localparam logic [31:0] OWN_ADDR_MIN  = 32'h0000_0001;
  localparam logic [31:0] OWN_ADDR_MAX  = 32'hDFFF_FFFE;
  localparam logic [31:0] ADDR_ZERO     = 32'h0000_0000;

  // non-volatile programming time and its cycle count at 20 MHz
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          NV_PROG_NS    = 1000;
  localparam int          NV_PROG_CYC   =
    (NV_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PROG_CNT_W    = 8;

  // log counters and status widths
  localparam int          LOG_CNT_W     = 8;
  localparam int          LOG_CODE_W    = 16;
  localparam int          TIME_W        = 32;
  localparam logic [7:0]  LOG_CNT_MAX   = 8'hFF;
  localparam logic [7:0]  LOG_CNT_ONE   = 8'h01;

  // link status bit positions
  localparam int          LNK_DUPLEX    = 0;
  localparam int          LNK_UP        = 1;
  localparam int          LNK_FAST      = 2;
  localparam int          LNK_W         = 3;

  // storage sequencer, gray coded along idle-program-done
  typedef enum logic [1:0] {
    IPO_IDLE = 2'b00,
    IPO_PROG = 2'b01,
    IPO_DONE = 2'b11
  } ipo_state_t;

  // storage operation in progress
  typedef enum logic [1:0] {
    IPO_OP_NONE  = 2'b00,
    IPO_OP_WRITE = 2'b01,
    IPO_OP_ERASE = 2'b10
  } ipo_op_t;

endpackage : ipo_pkg

// ===== core/ipo_edge.sv
// rising edge detector for a group of request relays
`timescale 1ns/10ps
module ipo_edge #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] prev;

  // remember last level; reset treats relays as off
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev <= '0;
    end else if (ce) begin
      prev <= level;
    end
  end

  // one pulse per off-to-on change, held relay gives nothing more
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_rise
      assign rise[g] = ce & level[g] & ~prev[g];
    end
  endgenerate

endmodule : ipo_edge

// ===== tb/ipo_store_properties.sv
// concurrent checks on the override store ports
`timescale 1ns/10ps
module ipo_store_properties #(
  parameter int NV_PROG_CYCLES = ipo_pkg::NV_PROG_CYC
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        power_up,
  input wire logic [31:0] param_own_addr,
  input wire logic        log_enable,
  input wire logic        batteryless_mode,
  input wire logic        phy_full_duplex,
  input wire logic        phy_link_up,
  input wire logic        phy_fast,
  input wire logic        override_enabled_flag,
  input wire logic [31:0] active_own_addr,
  input wire logic        store_busy,
  input wire logic        store_valid,
  input wire logic        write_done,
  input wire logic        clear_done,
  input wire logic        write_error,
  input wire logic [7:0]  error_log_count,
  input wire logic [2:0]  link_status
);
  logic [7:0] busy_len;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // length of the current busy spell
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !store_busy) busy_len <= 8'h00;
    else busy_len <= busy_len + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_fin;
    !store_busy && (write_done || clear_done);
  endsequence
  property p_busy_len;
    $fell(store_busy) |-> busy_len == NV_PROG_CYCLES + 1;
  endproperty
  property p_fin;
    $fell(store_busy) |-> s_fin;
  endproperty
  property p_done_valid;
    write_done |-> store_valid && $past(store_busy);
  endproperty
  property p_err_keep;
    write_error |-> $stable(store_valid) && !store_busy;
  endproperty
  property p_clr_empty;
    clear_done |-> !store_valid;
  endproperty
  property p_pwr_set;
    power_up && store_valid |=> override_enabled_flag;
  endproperty
  property p_pwr_empty;
    power_up && !store_valid |=> !override_enabled_flag &&
      active_own_addr == $past(param_own_addr);
  endproperty
  property p_hold;
    !$past(power_up) |-> $stable(active_own_addr);
  endproperty
  property p_log_off;
    !log_enable && !power_up |=> $stable(error_log_count);
  endproperty
  property p_bless;
    power_up && batteryless_mode |=> error_log_count == 8'h00;
  endproperty
  property p_link;
    $past(rst_n) |-> link_status ==
      $past({phy_fast, phy_link_up, phy_full_duplex});
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy");
  a_fin: assert property (p_fin) else $error("no done");
  a_done_valid: assert property (p_done_valid) else $error("done");
  a_err_keep: assert property (p_err_keep) else $error("error");
  a_clr_empty: assert property (p_clr_empty) else $error("clear");
  a_pwr_set: assert property (p_pwr_set) else $error("apply");
  a_pwr_empty: assert property (p_pwr_empty) else $error("param");
  a_hold: assert property (p_hold) else $error("address moved");
  a_log_off: assert property (p_log_off) else $error("log");
  a_bless: assert property (p_bless) else $error("log wipe");
  a_link: assert property (p_link) else $error("link status");
endmodule : ipo_store_properties

bind ipo_store ipo_store_properties #(.NV_PROG_CYCLES(NV_PROG_CYCLES)) chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .power_up(power_up),
  .param_own_addr(param_own_addr), .log_enable(log_enable),
  .batteryless_mode(batteryless_mode), .phy_full_duplex(phy_full_duplex),
  .phy_link_up(phy_link_up), .phy_fast(phy_fast),
  .override_enabled_flag(override_enabled_flag),
  .active_own_addr(active_own_addr), .store_busy(store_busy),
  .store_valid(store_valid), .write_done(write_done),
  .clear_done(clear_done), .write_error(write_error),
  .error_log_count(error_log_count), .link_status(link_status));

// ===== tb/ipo_host_model.sv
// behavioural host loading the data registers and pulsing the relays
`timescale 1ns/10ps
module ipo_host_model (
  input  wire logic ref_clk,
  output logic [15:0] data_regs [ipo_pkg::DATA_REGS],
  output logic        wr_req,
  output logic        clr_req
);
  // relays off, registers clear at start
  initial begin
    wr_req = 1'b0;
    clr_req = 1'b0;
    foreach (data_regs[i]) data_regs[i] = 16'h0000;
  end
  // octets as plain values, upper register first
  task automatic load(input logic [31:0] own, m, r);
    @(negedge ref_clk);
    data_regs[0] = own[31:16];
    data_regs[1] = own[15:0];
    data_regs[2] = m[31:16];
    data_regs[3] = m[15:0];
    data_regs[4] = r[31:16];
    data_regs[5] = r[15:0];
  endtask : load
  // off-to-on relay, held for the given cycles
  task automatic relay(input logic clr, input int hold);
    @(negedge ref_clk);
    if (clr) clr_req = 1'b1;
    else wr_req = 1'b1;
    repeat (hold) @(negedge ref_clk);
    wr_req = 1'b0;
    clr_req = 1'b0;
  endtask : relay
endmodule : ipo_host_model

// ===== tb/tb_top.sv
// self-checking bench of the address override store
`timescale 1ns/10ps
module tb_top;
  localparam int N = 2;
  logic        ref_clk = 1'b0, rst_n = 1'b0, mclr = 1'b0, pwr = 1'b0;
  logic        log_en = 1'b0, latched = 1'b0, bless = 1'b0, cass = 1'b0;
  logic        err_ev = 1'b0, acc_ev = 1'b0, ts_ev = 1'b0;
  logic [2:0]  phy = 3'h0;
  logic [31:0] p_own = 32'h0A00_0001, p_msk = 32'hFF00_0000;
  logic [31:0] p_rtr = 32'h0A00_00FE;
  logic [15:0] regs [ipo_pkg::DATA_REGS];
  logic        wr, clr, flag, busy, valid, w_done, c_done, w_err, ts_v;
  logic [31:0] a_own, a_msk, a_rtr, ts_last;
  logic [7:0]  e_cnt, a_cnt;
  logic [15:0] e_last;
  logic [2:0]  lnk;
  int          num_errors = 0, n_tests = 0, n_wr = 0, n_clr = 0, n_err = 0;

  always #25 ref_clk = ~ref_clk;
  // count the one-cycle answer pulses
  always @(posedge ref_clk) begin
    if (w_done === 1'b1) n_wr++;
    if (c_done === 1'b1) n_clr++;
    if (w_err === 1'b1) n_err++;
  end
  ////////////////////////////////////////////////////////////////////////////
  ipo_host_model host_u (.ref_clk(ref_clk), .data_regs(regs),
    .wr_req(wr), .clr_req(clr));
  ipo_store #(.NV_PROG_CYCLES(N)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .ce(1'b1), .override_data_regs(regs), .override_write_request(wr),
    .override_clear_request(clr), .memory_clear_request(mclr),
    .power_up(pwr), .param_own_addr(p_own), .param_mask(p_msk),
    .param_router(p_rtr), .cassette_present(cass), .log_enable(log_en),
    .log_latched(latched), .batteryless_mode(bless), .error_event(err_ev),
    .error_code(16'h1234), .access_event(acc_ev), .time_set_event(ts_ev),
    .time_set_value(32'h5A5A_0001), .phy_full_duplex(phy[0]),
    .phy_link_up(phy[1]), .phy_fast(phy[2]),
    .override_enabled_flag(flag), .active_own_addr(a_own),
    .active_mask(a_msk), .active_router(a_rtr), .store_busy(busy),
    .store_valid(valid), .write_done(w_done), .clear_done(c_done),
    .write_error(w_err), .error_log_count(e_cnt), .error_log_last(e_last),
    .access_log_count(a_cnt), .time_set_valid(ts_v),
    .time_set_last(ts_last), .link_status(lnk));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic wait_idle;
    int i = 0;
    repeat (2) @(negedge ref_clk);
    while (busy !== 1'b0 && i < 40) begin
      @(negedge ref_clk);
      i++;
    end
    check("busy", 0, busy);
    @(negedge ref_clk);
  endtask : wait_idle
  task automatic power;
    @(negedge ref_clk);
    pwr = 1'b1;
    @(negedge ref_clk);
    pwr = 1'b0;
    @(negedge ref_clk);
  endtask : power
  task automatic active(input logic [31:0] o, m, r, input logic f);
    check("flag", f, flag);
    check("own", o, a_own);
    check("mask", m, a_msk);
    check("router", r, a_rtr);
  endtask : active
  task automatic write_set(input logic [31:0] o, m, r, input int hold);
    n_wr = 0;
    n_err = 0;
    host_u.load(o, m, r);
    host_u.relay(1'b0, hold);
    wait_idle();
  endtask : write_set
  task automatic events;
    @(negedge ref_clk);
    err_ev = 1'b1;
    acc_ev = 1'b1;
    ts_ev = 1'b1;
    @(negedge ref_clk);
    err_ev = 1'b0;
    acc_ev = 1'b0;
    ts_ev = 1'b0;
    @(negedge ref_clk);
  endtask : events
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_write;
    power();
    active(p_own, p_msk, p_rtr, 1'b0);
    write_set(32'hC0A8_0A01, 32'hFFFF_FF00, 32'hC0A8_0AFE, 1);
    check("write", 1, n_wr);
    check("valid", 1, valid);
    active(p_own, p_msk, p_rtr, 1'b0);
    cass = 1'b1;
    p_own = 32'h0A00_0002;
    power();
    active(32'hC0A8_0A01, 32'hFFFF_FF00, 32'hC0A8_0AFE, '1);
    p_own = 32'h0A00_0003;
    power();
    active(32'hC0A8_0A01, 32'hFFFF_FF00, 32'hC0A8_0AFE, '1);
    write_set(32'hC0A8_0A05, 32'hFFFF_FF00, 32'hC0A8_0AFE, 10);
    check("held", 1, n_wr);
    $display("test write done");
  endtask : t_write
  task automatic t_zero;
    logic [31:0] m [3] = '{32'h0000_0000, 32'hFFFF_FF00, 32'h0000_0000};
    logic [31:0] r [3] = '{32'hC0A8_0AFE, 32'h0000_0000, 32'h0000_0000};
    for (int i = 0; i < 3; i++) begin
      write_set(32'hC0A8_0A09, m[i], r[i], 1);
      check("error", i < 2, n_err);
      check("write", i == 2, n_wr);
      power();
      active(i < 2 ? 32'hC0A8_0A05 : 32'hC0A8_0A09,
        i < 2 ? 32'hFFFF_FF00 : 32'h0, i < 2 ? 32'hC0A8_0AFE : 32'h0,
        1'b1);
    end
    $display("test zero done");
  endtask : t_zero
  task automatic t_clear;
    n_clr = 0;
    host_u.relay(1'b1, 1);
    wait_idle();
    check("clear", 1, n_clr);
    check("valid", 0, valid);
    power();
    active(p_own, p_msk, p_rtr, 1'b0);
    write_set(32'hC0A8_0A07, 32'hFFFF_FF00, 32'hC0A8_0AFE, 1);
    check("valid", 1, valid);
    @(negedge ref_clk);
    mclr = 1'b1;
    @(negedge ref_clk);
    mclr = 1'b0;
    wait_idle();
    check("memclr", 0, valid);
    power();
    active(p_own, p_msk, p_rtr, 1'b0);
    $display("test clear done");
  endtask : t_clear
  task automatic t_logs;
    events();
    check("errors off", 0, e_cnt);
    check("access off", 0, a_cnt);
    log_en = 1'b1;
    latched = 1'b1;
    events();
    check("errors", 1, e_cnt);
    check("code", 32'h1234, e_last);
    check("access", 1, a_cnt);
    check("time", 32'h5A5A_0001, ts_last);
    bless = 1'b1;
    power();
    check("wipe e", 0, e_cnt);
    check("wipe a", 0, a_cnt);
    check("wipe t", 0, ts_v);
    for (int k = 0; k < 8; k++) begin
      phy = k[2:0];
      repeat (2) @(negedge ref_clk);
      check("link", k, lnk);
    end
    $display("test logs done");
  endtask : t_logs
  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    check("reset", 0, valid);
    t_write();
    t_zero();
    t_clear();
    t_logs();
    end_of_test();
  end
  initial begin
    #1_000_000;
    num_errors++;
    end_of_test();
  end
endmodule : tb_top
